// ### src/gpf_defines.svh
`ifndef GPF_DEFINES_SVH
`define GPF_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define GPF_IDX_MODE 8'h27
`define GPF_IDX_STATE 8'h28
`define GPF_IDX_IO_EN 8'h26
`define GPF_ADDR_MODE 12'h09C
`define GPF_ADDR_STATE 12'h0A0
`define GPF_ADDR_IO_EN 12'h098

// Reset values.
`define GPF_RST_MODE 8'h00
`define GPF_RST_STATE 4'h0
`define GPF_RST_IO_EN 8'h00

// Field positions in the function control register.
`define GPF_OV_MODE_BIT 7
`define GPF_BUSY_SEL_BIT 5
`define GPF_ALERT_SEL_BIT 4
`define GPF_LANE_HI 3
`define GPF_LANE_LO 2
`define GPF_BUSY_EN_BIT 1
`define GPF_ALERT_EN_BIT 0
// Writable bits of the function control register (bit 6 reserved).
`define GPF_MODE_WMASK 8'hBF

// Field positions in the pin state register.
`define GPF_IN_LEVEL_LO 4
`define GPF_OUT_LEVEL_LO 0

// Field positions in the input/output enable register.
`define GPF_IN_EN_LO 4
`define GPF_OUT_EN_LO 0

`endif

// ### src/gpf_lane_decode.sv
// Turns the lane field into a lane count for the package variant.
module gpf_lane_decode (
  input wire logic [1:0] lane_field,
  input wire logic reduced_pkg,
  output gpf_pkg::gpf_lanes_t lanes
);

  // Codes 0 and 3 give one lane; code 2 gives four only on the full package.
  always_comb begin
    unique case (lane_field)
      2'h1: lanes = gpf_pkg::GPF_LANES_2;
      2'h2: lanes = reduced_pkg ? gpf_pkg::GPF_LANES_1
                                : gpf_pkg::GPF_LANES_4;
      2'h0, 2'h3: lanes = gpf_pkg::GPF_LANES_1;
    endcase
  end

endmodule

// ### src/gpf_pin_arbiter.sv
// Picks the owner of one pin from its claiming functions by fixed priority.
module gpf_pin_arbiter (
  input wire logic busy_claim,
  input wire logic alert_claim,
  input wire logic out_claim,
  input wire logic in_claim,
  output gpf_pkg::gpf_fn_t owner
);

  // Busy first, then alert, then output, then input.
  always_comb begin
    if (busy_claim) begin
      owner = gpf_pkg::GPF_FN_BUSY;
    end else if (alert_claim) begin
      owner = gpf_pkg::GPF_FN_ALERT;
    end else if (out_claim) begin
      owner = gpf_pkg::GPF_FN_OUT;
    end else if (in_claim) begin
      owner = gpf_pkg::GPF_FN_IN;
    end else begin
      owner = gpf_pkg::GPF_FN_NONE;
    end
  end

endmodule

// ### src/gpf_pin_function.sv
`include "gpf_defines.svh"

module gpf_pin_function (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reduced_pkg,
  input wire logic busy_flag,
  input wire logic threshold_alert_flag,
  output logic overvoltage_alert_status_bit,
  output logic [1:0] output_lane_select,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);

  logic [7:0] mode_reg;
  logic [3:0] output_pin_levels_reg;
  logic [7:0] io_en_reg;
  logic [3:0] input_pin_levels_reg;
  logic [3:0] input_pin_levels_next;
  gpf_pkg::gpf_lanes_t lanes;
  gpf_pkg::gpf_fn_t owner [4];
  logic [3:0] busy_claim;
  logic [3:0] alert_claim;
  logic [3:0] pin_valid;
  logic [3:0] pin_out_next;
  logic busy_sel;
  logic alert_sel;
  logic wr_access;
  logic rd_access;

  // Maps a byte address to a register hit; used for reads and writes.
  function automatic logic [1:0] reg_hit(input logic [11:0] addr);
    if (addr == `GPF_ADDR_MODE) begin
      reg_hit = 2'h1;
    end else if (addr == `GPF_ADDR_STATE) begin
      reg_hit = 2'h2;
    end else if (addr == `GPF_ADDR_IO_EN) begin
      reg_hit = 2'h3;
    end else begin
      reg_hit = 2'h0;
    end
  endfunction

  // The slave answers in the access phase with no wait states.
  assign pready = 1'b1;
  assign wr_access = psel && penable && pwrite && pstrb[0];
  assign rd_access = psel && penable && !pwrite;

  // Unmapped addresses answer with an error.
  assign pslverr = psel && penable && (reg_hit(paddr) == 2'h0);

  // Function control register; the reserved bit stays zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `GPF_RST_MODE;
    end else if (wr_access && reg_hit(paddr) == 2'h1) begin
      mode_reg <= pwdata[7:0] & `GPF_MODE_WMASK;
    end
  end

  // Output levels; on the reduced package only bit 0 is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_pin_levels_reg <= `GPF_RST_STATE;
    end else if (wr_access && reg_hit(paddr) == 2'h2) begin
      output_pin_levels_reg <= pwdata[3:0] & pin_valid;
    end
  end

  // Input and output enable bits of the pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_en_reg <= `GPF_RST_IO_EN;
    end else if (wr_access && reg_hit(paddr) == 2'h3) begin
      io_en_reg <= pwdata[7:0];
    end
  end

  // Pins 3..1 exist only on the full package.
  assign pin_valid = reduced_pkg ? 4'h1 : 4'hF;

  // Select bits count only on the full package.
  assign busy_sel = mode_reg[`GPF_BUSY_SEL_BIT] && !reduced_pkg;
  assign alert_sel = mode_reg[`GPF_ALERT_SEL_BIT] && !reduced_pkg;

  // Busy claims pin 0 or pin 3; alert claims pin 0 or pin 2.
  always_comb begin
    busy_claim = 4'h0;
    alert_claim = 4'h0;
    if (mode_reg[`GPF_BUSY_EN_BIT]) begin
      if (busy_sel) begin
        busy_claim[3] = 1'b1;
      end else begin
        busy_claim[0] = 1'b1;
      end
    end
    if (mode_reg[`GPF_ALERT_EN_BIT]) begin
      if (alert_sel) begin
        alert_claim[2] = 1'b1;
      end else begin
        alert_claim[0] = 1'b1;
      end
    end
  end

  // One arbiter per pin settles its owner.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_pin
      gpf_pin_arbiter u_arb (
        .busy_claim(busy_claim[i]),
        .alert_claim(alert_claim[i]),
        .out_claim(io_en_reg[`GPF_OUT_EN_LO + i] && pin_valid[i]),
        .in_claim(io_en_reg[`GPF_IN_EN_LO + i] && pin_valid[i]),
        .owner(owner[i])
      );
    end
  endgenerate

  // Per-pin drive value and sampled input level.
  always_comb begin
    pin_out_next = 4'h0;
    input_pin_levels_next = 4'h0;
    for (int i = 0; i < 4; i++) begin
      unique case (owner[i])
        gpf_pkg::GPF_FN_BUSY: pin_out_next[i] = busy_flag;
        gpf_pkg::GPF_FN_ALERT: pin_out_next[i] = threshold_alert_flag;
        gpf_pkg::GPF_FN_OUT: pin_out_next[i] = output_pin_levels_reg[i];
        gpf_pkg::GPF_FN_IN: input_pin_levels_next[i] = pin_in[i];
        gpf_pkg::GPF_FN_NONE: pin_out_next[i] = 1'b0;
        default: pin_out_next[i] = 1'b0;
      endcase
    end
  end

  // Pin drive levels and enables come from flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
    end else begin
      pin_out <= pin_out_next;
      for (int i = 0; i < 4; i++) begin
        pin_oe[i] <= (owner[i] != gpf_pkg::GPF_FN_NONE) &&
                     (owner[i] != gpf_pkg::GPF_FN_IN);
      end
    end
  end

  // Input levels are sampled every cycle; absent pins read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_pin_levels_reg <= 4'h0;
    end else begin
      input_pin_levels_reg <= input_pin_levels_next & pin_valid;
    end
  end

  // Status report of the threshold alert.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overvoltage_alert_status_bit <= 1'b0;
    end else begin
      overvoltage_alert_status_bit <= mode_reg[`GPF_OV_MODE_BIT] &&
                                      threshold_alert_flag;
    end
  end

  gpf_lane_decode u_lane (
    .lane_field(mode_reg[`GPF_LANE_HI:`GPF_LANE_LO]),
    .reduced_pkg(reduced_pkg),
    .lanes(lanes)
  );

  // Lane count registered onto the output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_lane_select <= 2'h0;
    end else begin
      output_lane_select <= lanes;
    end
  end

  // Read data is registered at the setup edge of a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (reg_hit(paddr))
        2'h1: prdata <= {24'h00_0000, mode_reg};
        2'h2: prdata <= {24'h00_0000, input_pin_levels_reg,
                         output_pin_levels_reg};
        2'h3: prdata <= {24'h00_0000, io_en_reg};
        2'h0: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### src/gpf_pkg.sv
package gpf_pkg;

  // Serial data output lane count.
  typedef enum logic [1:0] {
    GPF_LANES_1 = 2'h0,
    GPF_LANES_2 = 2'h1,
    GPF_LANES_4 = 2'h2
  } gpf_lanes_t;

  // Function that owns a pin.
  typedef enum logic [2:0] {
    GPF_FN_NONE = 3'h0,
    GPF_FN_BUSY = 3'h1,
    GPF_FN_ALERT = 3'h2,
    GPF_FN_OUT = 3'h3,
    GPF_FN_IN = 3'h4
  } gpf_fn_t;

endpackage

// ### testbench/gpf_pin_env.sv
// Outside logic on the four pins, resolving each wire from both drivers.
module gpf_pin_env (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] ext,
  output logic [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin shows the device level, otherwise the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ### testbench/gpf_pin_function_sva.sv
module gpf_pin_function_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic reduced_pkg,
  input wire logic busy_flag,
  input wire logic threshold_alert_flag,
  input wire logic overvoltage_alert_status_bit,
  input wire logic [1:0] output_lane_select,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe
);
  logic [7:0] mode_reg;
  logic [1:0] lane_exp;
  logic mode_wr, full, b0, b3, a0, a2, ov_exp;
  // Decodes a write to the function control register.
  assign mode_wr = psel && penable && pwrite && pstrb[0] &&
    paddr == 12'h09C;
  // Mirrors the function control register; bit 6 never holds a one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 8'h00;
    end else if (mode_wr) begin
      mode_reg <= pwdata[7:0] & 8'hBF;
    end
  end
  // Expected owners of each pin, with busy taking precedence.
  assign full = !reduced_pkg;
  assign b3 = mode_reg[1] && mode_reg[5] && full;
  assign b0 = mode_reg[1] && !b3;
  assign a2 = mode_reg[0] && mode_reg[4] && full;
  assign a0 = mode_reg[0] && !a2 && !b0;
  assign ov_exp = mode_reg[7] && threshold_alert_flag;
  assign lane_exp = mode_reg[3:2] == 2'h1 ? 2'h1 :
    (mode_reg[3:2] == 2'h2 && full) ? 2'h2 : 2'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_state;
    psel && penable && !pwrite && paddr == 12'h0A0;
  endsequence
  ov_report_a: assert property (overvoltage_alert_status_bit == $past(ov_exp))
    else $error("alert status mismatch");
  lane_count_a: assert property (output_lane_select == $past(lane_exp))
    else $error("lane count mismatch");
  busy_pin0_a: assert property (b0 |=> pin_oe[0] &&
    pin_out[0] == $past(busy_flag))
    else $error("busy not on pin 0");
  busy_pin3_a: assert property (b3 |=> pin_oe[3] &&
    pin_out[3] == $past(busy_flag))
    else $error("busy not on pin 3");
  alert_pin2_a: assert property (a2 |=> pin_oe[2] &&
    pin_out[2] == $past(threshold_alert_flag))
    else $error("alert not on pin 2");
  alert_pin0_a: assert property (a0 |=> pin_oe[0] &&
    pin_out[0] == $past(threshold_alert_flag))
    else $error("alert not on pin 0");
  small_pins_a: assert property (reduced_pkg && $past(reduced_pkg) |->
    pin_oe[3:1] == 3'h0) else $error("extra pin driven");
  small_read_a: assert property (reduced_pkg && $past(reduced_pkg, 3) ##0
    rd_state |-> prdata[7:5] == 3'h0)
    else $error("extra input bit set");
endmodule

bind gpf_pin_function gpf_pin_function_sva u_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .reduced_pkg(reduced_pkg), .busy_flag(busy_flag),
  .threshold_alert_flag(threshold_alert_flag),
  .overvoltage_alert_status_bit(overvoltage_alert_status_bit),
  .output_lane_select(output_lane_select), .pin_out(pin_out),
  .pin_oe(pin_oe));

// ### testbench/tb_top.sv
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: %h, expected %h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, ovs, reduced_pkg = 0, busy = 0, alert = 0;
  logic [1:0] lanes;
  logic [3:0] pin_in, pin_out, pin_oe, ext = 4'h0;
  int bad_count = 0, n_compared = 0, cyc = 0;
  gpf_pin_function dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reduced_pkg(reduced_pkg), .busy_flag(busy),
    .threshold_alert_flag(alert), .overvoltage_alert_status_bit(ovs),
    .output_lane_select(lanes), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  gpf_pin_env env (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
    .pin_in(pin_in));
  // Free-running bus clock.
  initial forever #4 pclk = ~pclk;
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One bus transfer; read data and error are taken at the ready edge.
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Write, then let the pin outputs follow the new register value.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  // Walks every lane code and checks the lane count.
  task automatic lane_walk();
    for (int c = 0; c < 4; c++) begin
      wr(12'h09C, 32'(c) << 2);
      `CHK(lanes, (c == 1) ? 2'h1 :
        (c == 2 && !reduced_pkg) ? 2'h2 : 2'h0)
    end
  endtask
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      close_out();
    end
  end
  // Main sequence.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(12'h09C, 32'h0);
    rd(12'h0A0, 32'h0);
    wr(12'h09C, 32'hFF);
    rd(12'h09C, 32'hBF);
    lane_walk();
    alert <= 1;
    wr(12'h09C, 32'h80);
    `CHK(ovs, 1'b1)
    wr(12'h09C, 32'h00);
    `CHK(ovs, 1'b0)
    busy <= 1;
    alert <= 0;
    wr(12'h09C, 32'h02);
    `CHK({pin_oe, pin_out}, 8'h11)
    wr(12'h09C, 32'h22);
    `CHK({pin_oe, pin_out}, 8'h88)
    busy <= 0;
    alert <= 1;
    wr(12'h09C, 32'h11);
    `CHK({pin_oe, pin_out}, 8'h44)
    wr(12'h09C, 32'h03);
    `CHK({pin_oe, pin_out}, 8'h10)
    wr(12'h098, 32'h0F);
    wr(12'h0A0, 32'h05);
    `CHK({pin_oe, pin_out}, 8'hF4)
    wr(12'h09C, 32'h00);
    `CHK({pin_oe, pin_out}, 8'hF5)
    ext <= 4'hA;
    wr(12'h098, 32'hF0);
    `CHK(pin_oe, 4'h0)
    rd(12'h0A0, 32'hA5);
    xfer(1'b0, 12'h0FC, 32'h0);
    `CHK({rerr, rdat}, 33'h100000000)
    `CHK(pready, 1'b1)
    // A write to an unmapped address is refused and changes nothing.
    xfer(1'b1, 12'h0FC, 32'hFF);
    `CHK(rerr, 1'b1)
    rd(12'h09C, 32'h0);
    reduced_pkg <= 1;
    ext <= 4'hF;
    wr(12'h0A0, 32'h0F);
    rd(12'h0A0, 32'h11);
    wr(12'h098, 32'h0F);
    `CHK({pin_oe, pin_out}, 8'h11)
    wr(12'h09C, 32'h33);
    `CHK({pin_oe, pin_out}, 8'h10)
    lane_walk();
    close_out();
  end
endmodule
